// >>> inc/irq_unit_pkg.sv
package irq_unit_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W   = 32;
	localparam int RADDR_W  = 8;
	localparam int PRIO_W   = 4;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [RADDR_W-1:0] OFF_CTRL     = 8'h00;
	localparam logic [RADDR_W-1:0] OFF_FPRIO    = 8'h04;
	localparam logic [RADDR_W-1:0] OFF_ENC_PRIO = 8'h08;
	localparam logic [RADDR_W-1:0] OFF_ENC_SRC  = 8'h0C;
	localparam logic [RADDR_W-1:0] OFF_VBASE    = 8'h10;
	localparam logic [RADDR_W-1:0] OFF_NODE0    = 8'h80;
	localparam int                 WORD_SHIFT   = 2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_GLB_EN_BIT = 0;
	localparam int CTRL_VEC_EN_BIT = 1;
	localparam int NODE_M_BIT      = 7;
	localparam int NODE_P_BIT      = 6;
	localparam int NODE_E_BIT      = 5;
	localparam int FPRIO_ACT_LSB   = 4;
	localparam int VPAGE_LSB       = 9;
	localparam int VEXIT_BIT       = 8;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [PRIO_W-1:0] PRIO_NONE  = 4'h0;
	localparam logic [PRIO_W-1:0] PRIO_MAX   = 4'hF;
	localparam logic [DATA_W-1:0] VBASE_RST  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_HALF,
		SIZE_WORD
	} access_size_e;

	typedef struct packed {
		logic              pend;
		logic              en;
		logic [PRIO_W-1:0] prio;
	} node_s;

	typedef struct packed {
		logic [DATA_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		access_size_e      size;
		logic              rd;
		logic              wr;
	} cpu_req_s;

endpackage

// >>> logic/irq_prio_encoder.sv
module irq_prio_encoder #(
	parameter int NODES = 32,
	parameter int SRC_W = $clog2(NODES)
) (
	input  wire logic                                 clk,
	input  wire logic                                 rst_all,
	input  wire irq_unit_pkg::node_s [NODES-1:0]      nodes,
	output logic [irq_unit_pkg::PRIO_W-1:0]           enc_prio_q,
	output logic [SRC_W-1:0]                          enc_src_q
);

	logic [irq_unit_pkg::PRIO_W-1:0] best_prio;
	logic [SRC_W-1:0]                best_src;

	// ----------------------------------------------------------------
	// Highest eligible node, lowest index on a tie
	// ----------------------------------------------------------------
	always_comb begin
		best_prio = irq_unit_pkg::PRIO_NONE;
		best_src  = '0;
		for (int i = 0; i < NODES; i++) begin
			if (nodes[i].pend && nodes[i].en &&
			    nodes[i].prio > best_prio) begin
				best_prio = nodes[i].prio;
				best_src  = SRC_W'(i);
			end
		end
	end

	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			enc_prio_q <= irq_unit_pkg::PRIO_NONE;
			enc_src_q  <= '0;
		end else begin
			enc_prio_q <= best_prio;
			enc_src_q  <= best_src;
		end
	end

endmodule

// >>> logic/priority_irq_unit.sv
// Design decisions made here: the strobed register port and the address map.
module priority_irq_unit #(
	parameter int NODES       = 32,
	parameter int STACK_DEPTH = 15
) (
	input  wire logic                                clk,
	input  wire logic                                rst,
	input  wire logic                                unit_keep_alive_flag,
	input  wire logic [NODES-1:0]                    src_event,
	input  wire logic [irq_unit_pkg::RADDR_W-1:0]    reg_addr,
	input  wire logic [irq_unit_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic                                reg_we,
	input  wire logic                                reg_re,
	output logic [irq_unit_pkg::DATA_W-1:0]          reg_rdata,
	input  wire irq_unit_pkg::cpu_req_s              cpu_req,
	output logic [irq_unit_pkg::DATA_W-1:0]          cpu_rdata,
	output logic                                     irq_request_low,
	output logic                                     vector_acknowledge,
	output logic                                     service_exit_pulse
);

	localparam int SRC_W   = $clog2(NODES);
	localparam int TBL_N   = NODES + 1;
	localparam int TBL_W   = $clog2(TBL_N);
	localparam int SP_W    = $clog2(STACK_DEPTH + 1);
	localparam int PW      = irq_unit_pkg::PRIO_W;
	localparam int DW      = irq_unit_pkg::DATA_W;

	// ----------------------------------------------------------------
	// Reset and state
	// ----------------------------------------------------------------
	logic rst_all;

	assign rst_all = rst | ~unit_keep_alive_flag;

	irq_unit_pkg::node_s [NODES-1:0] node_view;
	logic [NODES-1:0]                pend_q;
	logic [NODES-1:0]                en_q;
	logic [PW-1:0]                   prio_q [NODES];
	logic                            glb_en_q;
	logic                            vec_en_q;
	logic [PW-1:0]                   fprio_q;
	logic [PW-1:0]                   aprio_q;
	logic [DW-1:0]                   vbase_q;
	logic                            req_q;
	logic [PW-1:0]                   stack_q [STACK_DEPTH];
	logic [SP_W-1:0]                 sp_q;
	logic [DW-1:0]                   vec_table [TBL_N];
	logic [PW-1:0]                   enc_prio_q;
	logic [SRC_W-1:0]                enc_src_q;

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	function automatic logic node_hit(logic [irq_unit_pkg::RADDR_W-1:0] a);
		return a >= irq_unit_pkg::OFF_NODE0 &&
		       ((a - irq_unit_pkg::OFF_NODE0) >> irq_unit_pkg::WORD_SHIFT)
		       < NODES;
	endfunction

	function automatic logic [SRC_W-1:0] node_idx(
		logic [irq_unit_pkg::RADDR_W-1:0] a);
		logic [irq_unit_pkg::RADDR_W-1:0] d;
		d = (a - irq_unit_pkg::OFF_NODE0) >> irq_unit_pkg::WORD_SHIFT;
		return d[SRC_W-1:0];
	endfunction

	logic          wr_ctrl;
	logic          wr_fprio;
	logic          wr_vbase;
	logic          wr_node;
	logic [SRC_W-1:0] wr_idx;

	assign wr_ctrl  = reg_we && reg_addr == irq_unit_pkg::OFF_CTRL;
	assign wr_fprio = reg_we && reg_addr == irq_unit_pkg::OFF_FPRIO;
	assign wr_vbase = reg_we && reg_addr == irq_unit_pkg::OFF_VBASE;
	assign wr_node  = reg_we && node_hit(reg_addr);
	assign wr_idx   = node_idx(reg_addr);

	// ----------------------------------------------------------------
	// Vector port decode
	// ----------------------------------------------------------------
	logic          in_page;
	logic          at_base;
	logic          at_exit;
	logic          is_word;
	logic          vec_read;
	logic          ack_now;
	logic          exit_now;
	logic          cmp_active;
	logic [PW-1:0] thresh;
	logic [TBL_W-1:0] tbl_idx;
	logic [TBL_W-1:0] ack_idx;

	// all vector addresses follow the base register
	assign in_page = cpu_req.addr[DW-1:irq_unit_pkg::VPAGE_LSB] ==
	                 vbase_q[DW-1:irq_unit_pkg::VPAGE_LSB];
	assign at_base = in_page &&
	                 cpu_req.addr[irq_unit_pkg::VPAGE_LSB-1:0] == '0;
	assign at_exit = in_page && cpu_req.addr[irq_unit_pkg::VEXIT_BIT] &&
	                 cpu_req.addr[irq_unit_pkg::VEXIT_BIT-1:0] == '0;
	// narrow accesses have no side effect
	assign is_word = cpu_req.size == irq_unit_pkg::SIZE_WORD;
	// vector logic gated by its enable
	assign vec_read = cpu_req.rd && is_word && at_base && vec_en_q;
	assign exit_now = cpu_req.wr && is_word && at_exit && vec_en_q;

	// competes only above running and forced level
	assign thresh     = (fprio_q > aprio_q) ? fprio_q : aprio_q;
	assign cmp_active = enc_prio_q != irq_unit_pkg::PRIO_NONE &&
	                    enc_prio_q > thresh;
	// idle read gives default vector only
	assign ack_now    = vec_read && cmp_active;

	assign tbl_idx = cpu_req.addr[TBL_W+1:irq_unit_pkg::WORD_SHIFT];
	assign ack_idx = TBL_W'(enc_src_q) + TBL_W'(1);

	// ----------------------------------------------------------------
	// Priority encoder
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NODES; i++) begin
			node_view[i] = '{pend: pend_q[i], en: en_q[i], prio: prio_q[i]};
		end
	end

	irq_prio_encoder #(
		.NODES (NODES),
		.SRC_W (SRC_W)
	) u_enc (
		.clk        (clk),
		.rst_all    (rst_all),
		.nodes      (node_view),
		.enc_prio_q (enc_prio_q),
		.enc_src_q  (enc_src_q)
	);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// stores act from the next cycle
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			glb_en_q <= 1'b0;
			vec_en_q <= 1'b0;
			fprio_q  <= irq_unit_pkg::PRIO_NONE;
			vbase_q  <= irq_unit_pkg::VBASE_RST;
		end else begin
			if (wr_ctrl) begin
				glb_en_q <= reg_wdata[irq_unit_pkg::CTRL_GLB_EN_BIT];
				vec_en_q <= reg_wdata[irq_unit_pkg::CTRL_VEC_EN_BIT];
			end
			if (wr_fprio) begin
				fprio_q <= reg_wdata[PW-1:0];
			end
			if (wr_vbase) begin
				vbase_q <= {reg_wdata[DW-1:irq_unit_pkg::VPAGE_LSB],
				            irq_unit_pkg::VPAGE_LSB'(0)};
			end
		end
	end

	// ----------------------------------------------------------------
	// Source nodes: enable and priority
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			en_q <= '0;
			for (int i = 0; i < NODES; i++) begin
				prio_q[i] <= irq_unit_pkg::PRIO_NONE;
			end
		end else if (wr_node) begin
			en_q[wr_idx]   <= reg_wdata[irq_unit_pkg::NODE_E_BIT];
			prio_q[wr_idx] <= reg_wdata[PW-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Pending flags: survive keep-alive reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_q <= '0;
		end else begin
			for (int i = 0; i < NODES; i++) begin
				if (ack_now && enc_src_q == SRC_W'(i)) begin
					pend_q[i] <= 1'b0;
				end
				// software set or clear under modify bit
				if (wr_node && wr_idx == SRC_W'(i) &&
				    unit_keep_alive_flag &&
				    reg_wdata[irq_unit_pkg::NODE_M_BIT]) begin
					pend_q[i] <= reg_wdata[irq_unit_pkg::NODE_P_BIT];
				end
				if (src_event[i]) begin
					pend_q[i] <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Request output
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			req_q <= 1'b0;
		end else if (vec_read) begin
			req_q <= 1'b0;
		end else if (cmp_active && glb_en_q && vec_en_q) begin
			req_q <= 1'b1;
		end
	end

	assign irq_request_low = ~req_q;

	// ----------------------------------------------------------------
	// Running priority and nesting stack
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			aprio_q <= irq_unit_pkg::PRIO_NONE;
			sp_q    <= '0;
		end else if (ack_now) begin
			aprio_q <= enc_prio_q;
			if (sp_q < SP_W'(STACK_DEPTH)) begin
				sp_q <= sp_q + SP_W'(1);
			end
		end else if (exit_now) begin
			if (sp_q != '0) begin
				aprio_q <= stack_q[sp_q - SP_W'(1)];
				sp_q    <= sp_q - SP_W'(1);
			end else begin
				aprio_q <= irq_unit_pkg::PRIO_NONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (ack_now && sp_q < SP_W'(STACK_DEPTH)) begin
			stack_q[sp_q] <= aprio_q;
		end
	end

	// ----------------------------------------------------------------
	// Vector table memory and read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (cpu_req.wr && is_word && in_page &&
		    !cpu_req.addr[irq_unit_pkg::VEXIT_BIT] &&
		    tbl_idx < TBL_W'(TBL_N)) begin
			vec_table[tbl_idx] <= cpu_req.wdata;
		end
	end

	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			cpu_rdata <= irq_unit_pkg::WORD_ZERO;
		end else if (ack_now) begin
			cpu_rdata <= vec_table[ack_idx];
		end else if (cpu_req.rd && in_page &&
		             !cpu_req.addr[irq_unit_pkg::VEXIT_BIT] &&
		             tbl_idx < TBL_W'(TBL_N)) begin
			// base read without acknowledge is default entry
			cpu_rdata <= vec_table[tbl_idx];
		end else begin
			cpu_rdata <= irq_unit_pkg::WORD_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Event strobes
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			vector_acknowledge <= 1'b0;
			service_exit_pulse <= 1'b0;
		end else begin
			vector_acknowledge <= ack_now;
			service_exit_pulse <= exit_now;
		end
	end

	// ----------------------------------------------------------------
	// Register read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			reg_rdata <= irq_unit_pkg::WORD_ZERO;
		end else if (!reg_re) begin
			reg_rdata <= irq_unit_pkg::WORD_ZERO;
		end else if (node_hit(reg_addr)) begin
			reg_rdata <= DW'({1'b0,
			                  pend_q[node_idx(reg_addr)],
			                  en_q[node_idx(reg_addr)],
			                  1'b0,
			                  prio_q[node_idx(reg_addr)]});
		end else begin
			unique case (reg_addr)
				irq_unit_pkg::OFF_CTRL:
					reg_rdata <= DW'({vec_en_q, glb_en_q});
				irq_unit_pkg::OFF_FPRIO:
					reg_rdata <= DW'({aprio_q, fprio_q});
				irq_unit_pkg::OFF_ENC_PRIO:
					reg_rdata <= DW'(enc_prio_q);
				irq_unit_pkg::OFF_ENC_SRC:
					reg_rdata <= DW'(enc_src_q);
				irq_unit_pkg::OFF_VBASE:
					reg_rdata <= vbase_q;
				default:
					reg_rdata <= irq_unit_pkg::WORD_ZERO;
			endcase
		end
	end

endmodule

// >>> dv/priority_irq_unit_asserts.sv
module priority_irq_unit_asserts #(
	parameter int NODES = 32
) (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic                   unit_keep_alive_flag,
	input wire logic [NODES-1:0]       src_event,
	input wire logic [7:0]             reg_addr,
	input wire logic [31:0]            reg_wdata,
	input wire logic                   reg_we,
	input wire logic                   reg_re,
	input wire logic [31:0]            reg_rdata,
	input wire irq_unit_pkg::cpu_req_s cpu_req,
	input wire logic [31:0]            cpu_rdata,
	input wire logic                   irq_request_low,
	input wire logic                   vector_acknowledge,
	input wire logic                   service_exit_pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        vec_en_q;
	logic [22:0] page_q;
	logic        word;
	logic        hit_rd;
	logic        hit_ex;

	// ----------------------------------------------------------------
	// Shadow of table enable and vector page
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst
	            or negedge unit_keep_alive_flag) begin
		if (rst || !unit_keep_alive_flag) begin
			vec_en_q <= 1'b0;
			page_q   <= irq_unit_pkg::VBASE_RST[31:9];
		end else if (reg_we && reg_addr == irq_unit_pkg::OFF_CTRL) begin
			vec_en_q <= reg_wdata[irq_unit_pkg::CTRL_VEC_EN_BIT];
		end else if (reg_we && reg_addr == irq_unit_pkg::OFF_VBASE) begin
			page_q <= reg_wdata[31:9];
		end
	end

	assign word = cpu_req.size == irq_unit_pkg::SIZE_WORD;
	assign hit_rd = cpu_req.rd && word && cpu_req.addr[31:9] == page_q
		&& cpu_req.addr[8:0] == 9'h000 && vec_en_q;
	assign hit_ex = cpu_req.wr && word && cpu_req.addr[31:9] == page_q
		&& cpu_req.addr[8:0] == 9'h100 && vec_en_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_ka;
		!unit_keep_alive_flag |-> irq_request_low && !vector_acknowledge
			&& !service_exit_pulse;
	endproperty
	a_ka: assert property (p_ka) else $error("unit active in keep-alive reset");

	property p_ack_cause;
		vector_acknowledge |-> $past(hit_rd);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");

	property p_narrow;
		cpu_req.rd && !word |=> !vector_acknowledge;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow read acked");

	property p_exit_fire;
		hit_ex && unit_keep_alive_flag |=>
			service_exit_pulse || !unit_keep_alive_flag;
	endproperty
	a_exit_fire: assert property (p_exit_fire) else $error("exit lost");

	property p_exit_cause;
		service_exit_pulse |-> $past(hit_ex);
	endproperty
	a_exit_cause: assert property (p_exit_cause) else $error("stray exit");

	property p_ack_drop;
		hit_rd |=> irq_request_low;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request kept");

	property p_req_held;
		!irq_request_low && !hit_rd && unit_keep_alive_flag |=>
			!irq_request_low || !unit_keep_alive_flag;
	endproperty
	a_req_held: assert property (p_req_held) else $error("request dropped");

	property p_ge_clear;
		reg_we && reg_addr == irq_unit_pkg::OFF_CTRL
			&& !reg_wdata[irq_unit_pkg::CTRL_GLB_EN_BIT] ##1 irq_request_low
			|=> irq_request_low;
	endproperty
	a_ge_clear: assert property (p_ge_clear)
		else $error("late global disable");

	property p_fprio_max;
		reg_we && reg_addr == irq_unit_pkg::OFF_FPRIO
			&& reg_wdata[3:0] == irq_unit_pkg::PRIO_MAX ##1 irq_request_low
			|=> irq_request_low;
	endproperty
	a_fprio_max: assert property (p_fprio_max) else $error("forced max leaks");

	c_ack: cover property (vector_acknowledge);
	c_exit: cover property (service_exit_pulse);
	c_ka: cover property (!irq_request_low ##1 !unit_keep_alive_flag);
endmodule

bind priority_irq_unit priority_irq_unit_asserts #(.NODES(NODES)) chk (
	.clk, .rst, .unit_keep_alive_flag, .src_event, .reg_addr, .reg_wdata,
	.reg_we, .reg_re, .reg_rdata, .cpu_req, .cpu_rdata, .irq_request_low,
	.vector_acknowledge, .service_exit_pulse
);

// >>> dv/irq_cpu_model.sv
module irq_cpu_model (
	input  wire logic             clk,
	output irq_unit_pkg::cpu_req_s req,
	input  wire logic [31:0]      rdata,
	input  wire logic             ack,
	input  wire logic             ext
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] q;
	logic        ak;
	logic        ex;
	logic        served;

	initial begin
		req = '0;
		served = 1'b0;
	end

	// Released bus shows inverted address and data
	task automatic raw(input logic w, input logic [31:0] a,
		input irq_unit_pkg::access_size_e s, input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, size: s, rd: !w, wr: w};
		@(posedge clk);
		req <= '{addr: ~a, wdata: ~d, size: s, rd: 1'b0, wr: 1'b0};
		#1;
		q = rdata;
		ak = ack;
		ex = ext;
	endtask

	task automatic fetch(input logic [31:0] b);
		raw(1'b0, b, irq_unit_pkg::SIZE_WORD, 32'h0000_0000);
		served = ak;
	endtask

	task automatic leave(input logic [31:0] b);
		if (served) begin
			raw(1'b1, b + 32'h0000_0100, irq_unit_pkg::SIZE_WORD, 32'h0000_0000);
		end
		served = 1'b0;
	endtask
endmodule

// >>> dv/vectored_priority_irq_unit_bench.sv
module vectored_priority_irq_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int          NODES = 4;
	localparam logic [31:0] B1    = 32'h0000_1200;
	localparam logic [31:0] B2    = 32'h0000_1400;
	localparam logic [7:0]  A_CT  = irq_unit_pkg::OFF_CTRL;
	localparam logic [7:0]  A_FP  = irq_unit_pkg::OFF_FPRIO;
	localparam logic [7:0]  A_VB  = irq_unit_pkg::OFF_VBASE;
	localparam irq_unit_pkg::access_size_e W = irq_unit_pkg::SIZE_WORD;

	logic                   clk;
	logic                   rst;
	logic                   ka;
	logic [NODES-1:0]       src;
	logic [7:0]             reg_addr;
	logic [31:0]            reg_wdata;
	logic                   reg_we;
	logic                   reg_re;
	logic [31:0]            reg_rdata;
	irq_unit_pkg::cpu_req_s cpu_req;
	logic [31:0]            cpu_rdata;
	logic                   irq_request_low;
	logic                   vector_acknowledge;
	logic                   service_exit_pulse;
	int                     fails;
	int                     n_compared;

	priority_irq_unit #(.NODES(NODES)) uut (
		.clk, .rst, .unit_keep_alive_flag(ka), .src_event(src), .reg_addr,
		.reg_wdata, .reg_we, .reg_re, .reg_rdata, .cpu_req, .cpu_rdata,
		.irq_request_low, .vector_acknowledge, .service_exit_pulse
	);

	irq_cpu_model cpu (
		.clk, .req(cpu_req), .rdata(cpu_rdata), .ack(vector_acknowledge),
		.ext(service_exit_pulse)
	);

	function automatic logic [31:0] ent(input int k);
		return 32'h5A00_0000 + 32'(k);
	endfunction

	function automatic logic [7:0] nd(input int i);
		return irq_unit_pkg::OFF_NODE0 + 8'(4 * i);
	endfunction

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp1(input logic g, input logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 cmp(reg_rdata, e);
	endtask

	task automatic hold(input logic v);
		repeat (6) @(posedge clk);
		#1 cmp1(irq_request_low, v);
	endtask

	task automatic wirq(input logic v);
		#1;
		for (int i = 0; i < 20 && irq_request_low !== v; i++) begin
			@(posedge clk);
			#1;
		end
		cmp1(irq_request_low, v);
	endtask

	task automatic done(input int n);
		$display("test %0d done", n);
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#10000;
		fails++;
		results();
	end

	initial begin
		rst = 1'b1;
		ka = 1'b1;
		src = '0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		fails = 0;
		n_compared = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// ------------------------------------------------------------
		// Acknowledge, nesting, refusals, keep-alive, relocation
		// ------------------------------------------------------------
		wr(A_VB, B1);
		wr(A_CT, 32'h0000_0002);
		for (int k = 0; k <= NODES; k++) begin
			cpu.raw(1'b1, B1 + 32'(4 * k), W, ent(k));
		end
		wr(A_CT, 32'h0000_0003);
		wr(nd(1), 32'h0000_00E5);
		wirq(1'b0);
		rd(irq_unit_pkg::OFF_ENC_PRIO, 32'h0000_0005);
		rd(irq_unit_pkg::OFF_ENC_SRC, 32'h0000_0001);
		cpu.fetch(B1);
		cmp(cpu.q, ent(2));
		cmp1(cpu.ak, 1'b1);
		rd(nd(1), 32'h0000_0025);
		rd(A_FP, 32'h0000_0050);
		done(1);
		wr(nd(0), 32'h0000_00E1);
		hold(1'b1);
		cpu.leave(B1);
		cmp1(cpu.ex, 1'b1);
		wirq(1'b0);
		cpu.fetch(B1);
		cmp(cpu.q, ent(1));
		cpu.leave(B1);
		rd(A_FP, 32'h0000_0000);
		done(2);
		wr(nd(2), 32'h0000_00E3);
		wirq(1'b0);
		cpu.raw(1'b0, B1, irq_unit_pkg::SIZE_BYTE, 32'h0000_0000);
		cmp1(cpu.ak, 1'b0);
		cpu.raw(1'b1, B1 + 32'h0000_0100, irq_unit_pkg::SIZE_HALF,
			32'h0000_0000);
		cmp1(cpu.ex, 1'b0);
		wr(A_CT, 32'h0000_0001);
		cpu.fetch(B1);
		cmp1(cpu.ak, 1'b0);
		cpu.raw(1'b1, B1 + 32'h0000_0100, W, 32'h0000_0000);
		cmp1(cpu.ex, 1'b0);
		wr(A_CT, 32'h0000_0000);
		hold(1'b0);
		wr(A_CT, 32'h0000_0003);
		cpu.fetch(B1);
		cmp(cpu.q, ent(3));
		cpu.leave(B1);
		done(3);
		wr(nd(3), 32'h0000_0007);
		@(posedge clk);
		src[3] <= 1'b1;
		@(posedge clk);
		src <= '0;
		rd(nd(3), 32'h0000_0047);
		hold(1'b1);
		cpu.fetch(B1);
		cmp1(cpu.ak, 1'b0);
		cmp(cpu.q, ent(0));
		wr(nd(0), 32'h0000_00E1);
		wirq(1'b0);
		wr(nd(0), 32'h0000_00A1);
		hold(1'b0);
		cpu.fetch(B1);
		cmp1(cpu.ak, 1'b0);
		cmp(cpu.q, ent(0));
		cmp1(irq_request_low, 1'b1);
		wr(A_CT, 32'h0000_0002);
		wr(nd(0), 32'h0000_00E1);
		hold(1'b1);
		rd(A_CT, 32'h0000_0002);
		wr(A_CT, 32'h0000_0003);
		wirq(1'b0);
		cpu.fetch(B1);
		cmp(cpu.q, ent(1));
		cpu.leave(B1);
		done(4);
		wr(A_FP, 32'h0000_000F);
		wr(nd(3), 32'h0000_0027);
		hold(1'b1);
		wr(A_FP, 32'h0000_0000);
		wirq(1'b0);
		@(posedge clk);
		ka <= 1'b0;
		#1 cmp1(irq_request_low, 1'b1);
		wr(nd(3), 32'h0000_0000);
		@(posedge clk);
		ka <= 1'b1;
		rd(nd(3), 32'h0000_0040);
		rd(A_VB, irq_unit_pkg::VBASE_RST);
		wr(A_VB, B2);
		wr(A_CT, 32'h0000_0003);
		wr(nd(3), 32'h0000_0027);
		wirq(1'b0);
		cpu.fetch(B2);
		cmp(cpu.q, ent(4));
		cpu.leave(B2);
		cmp1(cpu.ex, 1'b1);
		done(5);
		results();
	end
endmodule
